// ===== include/mdc_pkg.sv
package mdc_pkg;
    localparam int CODE_W    = 9;               // internal delay code width
    localparam int USER_W    = 8;               // user code bus width
    localparam int NUM_LOOPS = 2;               // one master loop per I/O side
    localparam int TAPS      = 512;             // delay line taps
    localparam int TAP_W     = 9;
    localparam int CNT_W     = 16;              // period measure counter width
    localparam logic [CODE_W-1:0] CODE_RST   = 9'h000;
    localparam logic [3:0]        SETTLE_CNT = 4'h8;  // stable comparisons before lock
    localparam int SETTLE_W  = 4;
    localparam int QUARTER_SHIFT = 2;           // divide by four gives 90 degrees
    typedef enum logic [1:0] {
        MDC_IDLE,
        MDC_WAIT_RISE,
        MDC_MEASURE,
        MDC_COMPARE
    } mdc_state_type;
endpackage

// ===== src/mdc_slave_delay.sv
`timescale 1ns/1ps
// slave delay: shifts a sampled signal by the code plus two ref_clk-domain
// steps (input and output registers); modelled as a tapped shift register
module mdc_slave_delay (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic [mdc_pkg::CODE_W-1:0] delay_code,
    input  wire logic                       sig_in,
    output logic                            sig_out
);
    import mdc_pkg::*;

    logic [TAPS-1:0] line_q;
    logic            out_q;

    // tapped line; every tap shifts each clock
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            line_q <= '0;
        end else begin
            line_q <= {line_q[TAPS-2:0], sig_in};
        end
    end

    // output tap picked by the code, registered so the mux glitch never escapes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= line_q[delay_code];
        end
    end

    assign sig_out = out_q;
endmodule // mdc_slave_delay

// ===== src/mdc_master_delay_loop.sv
`timescale 1ns/1ps
// Contract
// - code equals delay-line setting for a quarter of the reference period
// - two independent master loops, one per I/O side, separate codes
// - strobe buffer slave shifts incoming strobe by ninety degrees
// - clock delay slave outputs a ninety-degree shifted clock copy
// - reset returns the master loop to its initial state
// - code_update_n low updates output code; high holds it
// - freeze high stops loop clock and oscillator clock glitch-free
// - freeze low restarts loop clock and oscillator clock
// - lock asserted only while the driven code is valid
// - slave delay code drives strobe buffer and clock delay slave
// - code also presented on an eight-bit user bus
// - each loop codes its own reference; slaves delay by the code
module mdc_master_delay_loop (
    input  wire logic                                 ref_clk,
    input  wire logic                                 resetn,
    input  wire logic [mdc_pkg::NUM_LOOPS-1:0]        meas_ref,
    input  wire logic [mdc_pkg::NUM_LOOPS-1:0]        code_update_n,
    input  wire logic [mdc_pkg::NUM_LOOPS-1:0]        freeze,
    input  wire logic [mdc_pkg::NUM_LOOPS-1:0]        strobe_in,
    input  wire logic [mdc_pkg::NUM_LOOPS-1:0]        slave_clk_in,
    output logic [mdc_pkg::NUM_LOOPS*mdc_pkg::CODE_W-1:0] slave_delay_code,
    output logic [mdc_pkg::NUM_LOOPS*mdc_pkg::USER_W-1:0] user_delay_code,
    output logic [mdc_pkg::NUM_LOOPS-1:0]             lock,
    output logic [mdc_pkg::NUM_LOOPS-1:0]             osc_clk_out,
    output logic [mdc_pkg::NUM_LOOPS-1:0]             strobe_delayed,
    output logic [mdc_pkg::NUM_LOOPS-1:0]             clk_delayed
);
    import mdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // structure of one loop
    //   - the reference is sampled on ref_clk; one ref_clk cycle is one tap
    //   - a period is counted between two sampled rises of the reference
    //   - a quarter of that count is the code, capped at the last tap
    //   - the measured code stays private until code_update_n lets it out
    //   - lock needs repeated matching measurements and a current output
    //   - freeze holds every master loop register but the output code, and the oscillator stand-in; the slave delay lines keep shifting
    // limitation: resolution is one ref_clk cycle, so the reference must be
    // several times slower than ref_clk for the code to mean anything
    // trade-off: a counter and a shift are cheaper than a phase detector
    // and a delay chain, and they behave alike in simulation
    //
    // the two loops share nothing but ref_clk and resetn, so each side
    // follows its own reference frequency
    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
            mdc_state_type         state_q;
            logic                  ref_q;
            logic [CNT_W-1:0]      cnt_q;
            logic [CODE_W-1:0]     meas_code_q;
            logic [CODE_W-1:0]     out_code_q;
            logic [SETTLE_W-1:0]   settle_q;
            logic                  locked_q;
            logic                  osc_q;
            logic [CNT_W-1:0]      quarter;
            logic                  rise;

            // the reference is sampled on ref_clk, which stands in for the delay line
            assign rise    = meas_ref[g] & ~ref_q;
            assign quarter = cnt_q >> QUARTER_SHIFT;

            // edge history of the reference; held while frozen
            // holding it keeps a rise that falls inside a freeze from being lost
            // or seen twice once the loop runs again
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ref_q <= 1'b0;
                end else if (!freeze[g]) begin
                    ref_q <= meas_ref[g];
                end
            end

            // period measurement; freeze gates the loop so it holds state, never half-counts
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    state_q     <= MDC_IDLE;
                    cnt_q       <= '0;
                    meas_code_q <= CODE_RST;
                end else if (!freeze[g]) begin
                    case (state_q)
                        MDC_IDLE: begin
                            state_q <= MDC_WAIT_RISE;
                        end
                        MDC_WAIT_RISE: begin
                            cnt_q <= '0;
                            if (rise) begin
                                state_q <= MDC_MEASURE;
                            end
                        end
                        MDC_MEASURE: begin
                            if (rise) begin
                                state_q <= MDC_COMPARE;
                            end else if (cnt_q != {CNT_W{1'b1}}) begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                        MDC_COMPARE: begin
                            // saturate at the longest tap, the line cannot reach further
                            if (quarter > CNT_W'(TAPS - 1)) begin
                                meas_code_q <= CODE_W'(TAPS - 1);
                            end else begin
                                meas_code_q <= quarter[CODE_W-1:0];
                            end
                            // the compare cycle is already one cycle of the next
                            // period; restarting at zero would make every period
                            // after the first one cycle short
                            cnt_q   <= {{(CNT_W-1){1'b0}}, 1'b1};
                            state_q <= MDC_MEASURE;
                        end
                        default: begin
                            state_q <= MDC_IDLE;
                        end
                    endcase
                end
            end

            // settle counter: lock only after repeated matching measurements
            // the new quarter is held against the code kept from the last
            // period; one mismatch starts the count again, so a drifting
            // reference never shows lock
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    settle_q <= '0;
                    locked_q <= 1'b0;
                end else if (!freeze[g] && state_q == MDC_COMPARE) begin
                    if (quarter[CODE_W-1:0] == meas_code_q) begin
                        if (settle_q == SETTLE_CNT) begin
                            locked_q <= 1'b1;
                        end else begin
                            settle_q <= settle_q + 1'b1;
                        end
                    end else begin
                        settle_q <= '0;
                        locked_q <= 1'b0;
                    end
                end
            end

            // output code moves only while update is requested
            // the user keeps code_update_n high across memory transfers so the slaves
            // never see the code change mid-burst
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    out_code_q <= CODE_RST;
                end else if (!code_update_n[g]) begin
                    out_code_q <= meas_code_q;
                end
            end

            // ring oscillator stand-in; stops phase-preserving at its current level while frozen
            // gating the toggle, not the clock, keeps the stop free of runt pulses
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    osc_q <= 1'b0;
                end else if (!freeze[g]) begin
                    osc_q <= ~osc_q;
                end
            end

            assign slave_delay_code[g*CODE_W +: CODE_W] = out_code_q;
            assign user_delay_code[g*USER_W +: USER_W]  = out_code_q[CODE_W-1 -: USER_W];
            // lock drops if the presented code lags a changed measurement
            // so a held output never claims to match a reference that moved
            assign lock[g]        = locked_q & (out_code_q == meas_code_q);
            assign osc_clk_out[g] = osc_q;

            // both slaves take the presented code, never the private one,
            // so they move together and only when update allows
            // strobe buffer slave: centres the strobe in the data eye
            mdc_slave_delay u_strobe_delay_buffer (
                .ref_clk    (ref_clk),
                .resetn     (resetn),
                .delay_code (out_code_q),
                .sig_in     (strobe_in[g]),
                .sig_out    (strobe_delayed[g])
            );

            // clock delay slave: quarter-period shifted clock copy
            mdc_slave_delay u_clock_delay_slave (
                .ref_clk    (ref_clk),
                .resetn     (resetn),
                .delay_code (out_code_q),
                .sig_in     (slave_clk_in[g]),
                .sig_out    (clk_delayed[g])
            );
        end
    endgenerate
endmodule // mdc_master_delay_loop

// ===== bench/mdc_master_delay_loop_properties.sv
`timescale 1ns/1ps
module mdc_master_delay_loop_properties (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic [1:0]  code_update_n,
    input wire logic [1:0]  freeze,
    input wire logic [17:0] slave_delay_code,
    input wire logic [15:0] user_delay_code,
    input wire logic [1:0]  lock,
    input wire logic [1:0]  osc_clk_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // code, lock and oscillator against their causes
    a_user_code_pair: assert property (user_delay_code == {slave_delay_code[17:10], slave_delay_code[8:1]})
        else $error("user code differs from slave code");
    a_code_held: assert property (code_update_n[0] |=> $stable(slave_delay_code[8:0]))
        else $error("loop 0 code moved while held");
    a_code_moves_late: assert property ($changed(slave_delay_code[17:9]) |-> !$past(code_update_n[1]))
        else $error("loop 1 code moved without update");
    a_lock_in_reset: assert property (disable iff (1'b0) !resetn |-> lock == 2'b00)
        else $error("lock high in reset");
    a_lock_settles: assert property ($rose(resetn) |-> (lock == 2'b00) [*8])
        else $error("lock too early after reset");
    a_code_from_reset: assert property ($rose(resetn) |-> slave_delay_code == 18'h00000)
        else $error("code not cleared by reset");
    a_osc_running: assert property (!freeze[0] |=> osc_clk_out[0] != $past(osc_clk_out[0]))
        else $error("oscillator not toggling");
    a_osc_frozen: assert property (freeze[1] |=> $stable(osc_clk_out[1]))
        else $error("oscillator moved while frozen");
    c_lock: cover property ($rose(lock[0]));
    c_freeze: cover property ($fell(freeze[1]));
    c_hold: cover property (code_update_n[0] && !lock[0]);
endmodule // mdc_master_delay_loop_properties
bind mdc_master_delay_loop mdc_master_delay_loop_properties u_props (.ref_clk(ref_clk),
    .resetn(resetn), .code_update_n(code_update_n), .freeze(freeze), .lock(lock),
    .slave_delay_code(slave_delay_code), .user_delay_code(user_delay_code), .osc_clk_out(osc_clk_out));

// ===== bench/mdc_ref_source.sv
`timescale 1ns/1ps
module mdc_ref_source (
    input  wire logic       ref_clk,
    input  wire logic [7:0] period0,
    input  wire logic [7:0] period1,
    output logic [1:0]      meas_ref,
    output logic [1:0]      slave_clk_in
);
    logic [7:0] cnt0_q = 8'h00;
    logic [7:0] cnt1_q = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // references run free, high for the first half of each period
    always @(posedge ref_clk) begin
        cnt0_q <= (cnt0_q >= period0 - 8'h01) ? 8'h00 : cnt0_q + 8'h01;
        cnt1_q <= (cnt1_q >= period1 - 8'h01) ? 8'h00 : cnt1_q + 8'h01;
    end
    assign meas_ref = {cnt1_q < (period1 >> 1), cnt0_q < (period0 >> 1)};
    assign slave_clk_in = meas_ref; // same rate as the reference
endmodule // mdc_ref_source

// ===== bench/test_master_delay_code_generator.sv
`timescale 1ns/1ps
module test_master_delay_code_generator;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  upd_n = 2'h0, frz = 2'h0, stb = 2'h0, mref, sclk, lock, lock_p, osc, sdel, cdel;
    logic [17:0] code;
    logic [15:0] ucode;
    logic [7:0]  p0, p1;
    logic [31:0] seed = 32'h000150D4;
    logic [8:0]  eq [2][$];
    logic [1:0]  dq [$];
    int          failures = 0, cmp_count = 0, dly = 0;
    always #25 ref_clk = ~ref_clk;
    mdc_ref_source u_src (.ref_clk(ref_clk), .period0(p0), .period1(p1), .meas_ref(mref),
        .slave_clk_in(sclk));
    mdc_master_delay_loop DUT (.ref_clk(ref_clk), .resetn(resetn), .meas_ref(mref),
        .code_update_n(upd_n), .freeze(frz), .strobe_in(stb), .slave_clk_in(sclk),
        .slave_delay_code(code), .user_delay_code(ucode), .lock(lock), .osc_clk_out(osc),
        .strobe_delayed(sdel), .clk_delayed(cdel));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic test_done;
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_code(input logic [8:0] e, input logic [8:0] c, input logic [7:0] u);
        cmp_count++;
        if ({c, u} !== {e, e[8:1]}) begin
            failures++;
            $display("wrong value code exp %h got %h", {e, e[8:1]}, {c, u});
        end
    endtask
    task automatic cmp_bits(input string n, input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic wait_lock(input int g);
        int n;
        n = 0;
        while (lock[g] !== 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 4000) failures++;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watcher: code checked at each lock rise, delayed bits every cycle
    always @(negedge ref_clk) begin
        for (int g = 0; g < 2; g++)
            if (lock[g] === 1'b1 && lock_p[g] === 1'b0 && eq[g].size() > 0)
                cmp_code(eq[g].pop_front(), code[g*9+:9], ucode[g*8+:8]);
        if (dq.size() > dly) cmp_bits("delayed", dq.pop_front(), {cdel[0], sdel[0]});
        lock_p = lock;
    end
    initial begin
        seed = xs(seed);
        p0 = 8'h08 + {3'h0, seed[4:0]};
        seed = xs(seed);
        p1 = 8'h28 + {3'h0, seed[4:0]};
        eq[0].push_back({1'b0, (p0 - 8'h01) >> 2});
        eq[1].push_back({1'b0, (p1 - 8'h01) >> 2});
        repeat (12) @(posedge ref_clk);
        #2 resetn = 1'b1;
        wait_lock(0);
        wait_lock(1);
        // random strobe bits while the update control stays steady
        dly = ((p0 - 8'h01) >> 2) + 2;
        repeat (60) begin
            @(posedge ref_clk);
            #2 seed = xs(seed);
            stb = seed[1:0];
            dq.push_back({sclk[0], stb[0]});
        end
        // hold loop 0 while its reference moves, then let it follow
        upd_n[0] = 1'b1;
        p0 = p0 + 8'h08;
        #20000 cmp_code({1'b0, (p0 - 8'h09) >> 2}, code[8:0], ucode[7:0]);
        cmp_bits("lock", 2'h2, lock);
        eq[0].push_back({1'b0, (p0 - 8'h01) >> 2});
        upd_n[0] = 1'b0;
        wait_lock(0);
        // stop loop 1 a while; lock is held through it, so the wait returns at release
        #2 frz[1] = 1'b1;
        #1500 frz[1] = 1'b0;
        wait_lock(1);
        #2 resetn = 1'b0;
        #100 cmp_code(9'h000, code[8:0], ucode[7:0]);
        cmp_bits("lock", 2'h0, lock);
        eq[0].push_back({1'b0, (p0 - 8'h01) >> 2});
        eq[1].push_back({1'b0, (p1 - 8'h01) >> 2});
        #50 resetn = 1'b1;
        wait_lock(0);
        wait_lock(1);
        #100 test_done();
    end
    // watchdog well past the expected few thousand cycles
    initial begin
        #2000000 failures++;
        test_done();
    end
endmodule // test_master_delay_code_generator
